// >>> sim/fpet_flash_model.sv
// flash array model: measures the lengths of the timing runs it is given
// assumes the sequencer levels change on the rising clock edge
`timescale 1ns/1ps
module fpet_flash_model (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic busy_in,
	input wire logic pgm_in,
	input wire logic erase_in,
	input wire logic req_in,
	output logic [15:0] run_len_out [4],
	output logic [15:0] prog_sum_out
);
	logic [15:0] cnt_r [4];
	logic [3:0] lvl;
	// 0 program, 1 erase, 2 busy, 3 end wait
	assign lvl = {busy_in & ~pgm_in & ~erase_in & ~req_in, busy_in, erase_in, pgm_in};
	// program periods since the last erase
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) prog_sum_out <= 16'h0;
		else if (erase_in) prog_sum_out <= 16'h0;
		else if (pgm_in) prog_sum_out <= prog_sum_out + 16'h1;
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		for (int i = 0; i < 4; i++) begin
			if (!resetn_in) begin
				cnt_r[i] <= 16'h0;
				run_len_out[i] <= 16'h0;
			end else if (lvl[i]) begin
				cnt_r[i] <= cnt_r[i] + 16'h1;
			end else if (cnt_r[i] != 16'h0) begin
				run_len_out[i] <= cnt_r[i];
				cnt_r[i] <= 16'h0;
			end
		end
	end
endmodule

// >>> sim/fpet_seq_test.sv
// testbench of the flash program/erase timing sequencer
// assumes shortened erase counts of 40 and 20 cycles
`timescale 1ns/1ps
module fpet_seq_test;
	logic CLK_IN = 1'b0;
	logic RESETN_IN = 1'b0;
	logic START_IN = 1'b0;
	logic NEXT_IN = 1'b0;
	logic LAST_IN = 1'b0;
	logic [2:0] OP_IN = 3'h0;
	logic BUSY_OUT, PGM_OUT, ERASE_OUT, WORD_REQ_OUT, DONE_OUT;
	logic [5:0] POS_OUT;
	logic [15:0] run_len [4];
	int err_total = 0;
	int samples_checked = 0;
	logic [15:0] prog_sum;
	// 10 ms at the slowest and 20 ms at the fastest timing clock, in periods
	localparam int CPT_LIMIT = fpet_pkg::FPET_FREQ_MIN_KHZ * 10;
	localparam int CME_MIN = fpet_pkg::FPET_FREQ_MAX_KHZ * 20;
	localparam logic [15:0] PGM_SUM = 16'(fpet_pkg::FPET_WORD_CYCLES +
		3 * fpet_pkg::FPET_BLK_FIRST_CYCLES + 65 * fpet_pkg::FPET_BLK_NEXT_CYCLES);

	always #10 CLK_IN = ~CLK_IN;

	fpet_seq #(.MASS_CYCLES(40), .SEG_CYCLES(20)) DUT (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
		.START_IN(START_IN), .OP_IN(OP_IN), .NEXT_IN(NEXT_IN), .LAST_IN(LAST_IN),
		.BUSY_OUT(BUSY_OUT), .PGM_OUT(PGM_OUT), .ERASE_OUT(ERASE_OUT),
		.WORD_REQ_OUT(WORD_REQ_OUT), .DONE_OUT(DONE_OUT), .POS_OUT(POS_OUT));
	fpet_flash_model FM (.clk_in(CLK_IN), .resetn_in(RESETN_IN), .busy_in(BUSY_OUT),
		.pgm_in(PGM_OUT), .erase_in(ERASE_OUT), .req_in(WORD_REQ_OUT), .run_len_out(run_len),
		.prog_sum_out(prog_sum));

	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("BAD %s expected %0d seen %0d", name, exp, got);
			err_total++;
		end
	endtask

	// run one operation; poke re-issues a start mid-run
	task op(input logic [2:0] code, input int nwords, input int poke);
		int n;
		int k;
		n = 0;
		k = 0;
		@(negedge CLK_IN);
		START_IN = 1'b1;
		OP_IN = code;
		@(negedge CLK_IN);
		START_IN = 1'b0;
		while (DONE_OUT !== 1'b1 && k < 4000) begin
			@(negedge CLK_IN);
			k++;
			NEXT_IN = 1'b0;
			LAST_IN = 1'b0;
			START_IN = (k == poke);
			OP_IN = (k == poke) ? fpet_pkg::FPET_OP_SEG : code;
			if (WORD_REQ_OUT === 1'b1) begin
				chk("position", 16'(n), {10'h0, POS_OUT});
				NEXT_IN = (n < nwords);
				LAST_IN = (n >= nwords);
				n++;
			end
		end
		chk("done", 16'h1, {15'h0, DONE_OUT});
		// the model latches a run one edge after it ends
		@(negedge CLK_IN);
	endtask

	task t_word;
		op(fpet_pkg::FPET_OP_WORD, 0, 5);
		chk("word program", 16'd30, run_len[0]);
		chk("word busy", 16'd30, run_len[2]);
		chk("refused erase", 16'h0, run_len[1]);
	endtask

	task t_block;
		op(fpet_pkg::FPET_OP_BLOCK, 0, 0);
		chk("first word", 16'd25, run_len[0]);
		chk("end wait", 16'd6, run_len[3]);
		op(fpet_pkg::FPET_OP_BLOCK, 2, 0);
		chk("next word", 16'd18, run_len[0]);
		chk("end wait", 16'd6, run_len[3]);
		op(fpet_pkg::FPET_OP_BLOCK, 70, 0);
		chk("last position", 16'd63, {10'h0, POS_OUT});
		chk("next word", 16'd18, run_len[0]);
		chk("end wait", 16'd6, run_len[3]);
		chk("program sum", PGM_SUM, prog_sum);
		chk("program limit", 16'h1, {15'h0, prog_sum <= 16'(CPT_LIMIT)});
	endtask

	task t_erase;
		int mass_sum;
		mass_sum = 0;
		op(fpet_pkg::FPET_OP_SEG, 0, 0);
		chk("segment erase", 16'd20, run_len[1]);
		chk("program sum erased", 16'h0, prog_sum);
		while (mass_sum < CME_MIN) begin
			op(fpet_pkg::FPET_OP_MASS, 0, 0);
			chk("mass erase", 16'd40, run_len[1]);
			mass_sum += 40;
		end
		@(negedge CLK_IN);
		START_IN = 1'b1;
		OP_IN = 3'h7;
		@(negedge CLK_IN);
		START_IN = 1'b0;
		repeat (3) @(negedge CLK_IN);
		chk("invalid op", 16'h0, {15'h0, BUSY_OUT});
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		err_total++;
		stop_test();
	end

	initial begin
		repeat (12) @(negedge CLK_IN);
		RESETN_IN = 1'b1;
		t_word();
		t_block();
		t_erase();
		stop_test();
	end
endmodule

// >>> verilog/fpet_pkg.sv
// package for the flash program/erase timing sequencer
// assumes the clock is the divided timing-generator clock
package fpet_pkg;
	localparam int FPET_WORD_CYCLES = 30;
	localparam int FPET_BLK_FIRST_CYCLES = 25;
	localparam int FPET_BLK_NEXT_CYCLES = 18;
	localparam int FPET_BLK_END_CYCLES = 6;
	localparam int FPET_MASS_CYCLES = 10593;
	localparam int FPET_SEG_CYCLES = 4819;
	localparam int FPET_BLK_WORDS = 64;
	localparam int FPET_CNT_W = 14;
	// clock limits kept by the configuring party, in kHz
	localparam int FPET_FREQ_MIN_KHZ = 257;
	localparam int FPET_FREQ_MAX_KHZ = 476;
	// operation codes on the command port
	localparam logic [2:0] FPET_OP_WORD = 3'h1;
	localparam logic [2:0] FPET_OP_BLOCK = 3'h2;
	localparam logic [2:0] FPET_OP_SEG = 3'h3;
	localparam logic [2:0] FPET_OP_MASS = 3'h4;
	typedef enum logic [2:0] {
		FPET_IDLE, FPET_WORD, FPET_BFIRST, FPET_BWAIT, FPET_BNEXT, FPET_BEND, FPET_ERASE
	} fpet_state_type;
endpackage

// >>> verilog/fpet_seq.sv
// flash program/erase timing sequencer top
// assumes commands come from the flash controller on the timing-generator clock
`timescale 1ns/1ps
module fpet_seq #(
	parameter int CNT_W = fpet_pkg::FPET_CNT_W,
	parameter int MASS_CYCLES = fpet_pkg::FPET_MASS_CYCLES,
	parameter int SEG_CYCLES = fpet_pkg::FPET_SEG_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic START_IN,
	input wire logic [2:0] OP_IN,
	input wire logic NEXT_IN,
	input wire logic LAST_IN,
	output logic BUSY_OUT,
	output logic PGM_OUT,
	output logic ERASE_OUT,
	output logic WORD_REQ_OUT,
	output logic DONE_OUT,
	output logic [5:0] POS_OUT
);
	fpet_pkg::fpet_state_type state_r, state_nxt;
	logic [5:0] pos_r;
	logic last_r;
	logic load;
	logic [CNT_W-1:0] len;
	logic step_done;
	localparam logic [5:0] LAST_POS = 6'(fpet_pkg::FPET_BLK_WORDS - 1);
	// accept a new command only while idle
	wire go = (state_r == fpet_pkg::FPET_IDLE) && START_IN;
	wire op_word = OP_IN == fpet_pkg::FPET_OP_WORD;
	wire op_blk = OP_IN == fpet_pkg::FPET_OP_BLOCK;
	wire op_seg = OP_IN == fpet_pkg::FPET_OP_SEG;
	wire op_mass = OP_IN == fpet_pkg::FPET_OP_MASS;
	wire go_ok = go && (op_word || op_blk || op_seg || op_mass);
	// next word taken while waiting, or forced end at position 63
	wire blk_more = (state_r == fpet_pkg::FPET_BWAIT) && NEXT_IN && !last_r;
	wire blk_stop = (state_r == fpet_pkg::FPET_BWAIT) && last_r;
	fpet_timer #(.CNT_W(CNT_W)) u_timer (
		.clk_in(CLK_IN),
		.resetn_in(RESETN_IN),
		.load_in(load),
		.len_in(len),
		.done_out(step_done)
	);
	always_comb begin
		state_nxt = state_r;
		load = 1'b0;
		len = '0;
		case (state_r)
			fpet_pkg::FPET_IDLE: begin
				if (go_ok) begin
					load = 1'b1;
					if (op_word) begin
						state_nxt = fpet_pkg::FPET_WORD;
						len = CNT_W'(fpet_pkg::FPET_WORD_CYCLES);
					end else if (op_blk) begin
						state_nxt = fpet_pkg::FPET_BFIRST;
						len = CNT_W'(fpet_pkg::FPET_BLK_FIRST_CYCLES);
					end else if (op_seg) begin
						state_nxt = fpet_pkg::FPET_ERASE;
						len = CNT_W'(SEG_CYCLES);
					end else begin
						state_nxt = fpet_pkg::FPET_ERASE;
						len = CNT_W'(MASS_CYCLES);
					end
				end
			end
			fpet_pkg::FPET_WORD, fpet_pkg::FPET_ERASE: begin
				if (step_done) state_nxt = fpet_pkg::FPET_IDLE;
			end
			fpet_pkg::FPET_BFIRST, fpet_pkg::FPET_BNEXT: begin
				if (step_done) state_nxt = fpet_pkg::FPET_BWAIT;
			end
			fpet_pkg::FPET_BWAIT: begin
				if (blk_stop || (LAST_IN && !NEXT_IN)) begin
					load = 1'b1;
					state_nxt = fpet_pkg::FPET_BEND;
					len = CNT_W'(fpet_pkg::FPET_BLK_END_CYCLES);
				end else if (blk_more) begin
					load = 1'b1;
					state_nxt = fpet_pkg::FPET_BNEXT;
					len = CNT_W'(fpet_pkg::FPET_BLK_NEXT_CYCLES);
				end
			end
			fpet_pkg::FPET_BEND: begin
				if (step_done) state_nxt = fpet_pkg::FPET_IDLE;
			end
			default: state_nxt = fpet_pkg::FPET_IDLE;
		endcase
	end
	wire busy_nxt = state_nxt != fpet_pkg::FPET_IDLE;
	wire pgm_nxt = (state_nxt == fpet_pkg::FPET_WORD) || (state_nxt == fpet_pkg::FPET_BFIRST) ||
		(state_nxt == fpet_pkg::FPET_BNEXT);
	wire done_nxt = (state_r != fpet_pkg::FPET_IDLE) && !busy_nxt;
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_r <= fpet_pkg::FPET_IDLE;
			pos_r <= 6'h00;
			last_r <= 1'b0;
			BUSY_OUT <= 1'b0;
			PGM_OUT <= 1'b0;
			ERASE_OUT <= 1'b0;
			WORD_REQ_OUT <= 1'b0;
			DONE_OUT <= 1'b0;
			POS_OUT <= 6'h00;
		end else begin
			state_r <= state_nxt;
			BUSY_OUT <= busy_nxt;
			PGM_OUT <= pgm_nxt;
			ERASE_OUT <= state_nxt == fpet_pkg::FPET_ERASE;
			WORD_REQ_OUT <= state_nxt == fpet_pkg::FPET_BWAIT;
			DONE_OUT <= done_nxt;
			if (go_ok) pos_r <= 6'h00;
			else if (blk_more) pos_r <= pos_r + 6'h01;
			last_r <= (go_ok ? 6'h00 : (blk_more ? pos_r + 6'h01 : pos_r)) == LAST_POS;
			POS_OUT <= go_ok ? 6'h00 : (blk_more ? pos_r + 6'h01 : pos_r);
		end
	end
	// checks
	int unsigned run_cnt;
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) run_cnt <= 0;
		else if (load) run_cnt <= 1;
		else run_cnt <= run_cnt + 1;
	end
	property p_word_len;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(go_ok && op_word) |=> PGM_OUT [*8] ##0 (BUSY_OUT && !DONE_OUT);
	endproperty
	a_word_len: assert property (p_word_len) else $error("word program too short");
	property p_word_end;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(state_r == fpet_pkg::FPET_WORD && step_done) |-> run_cnt == 30;
	endproperty
	a_word_end: assert property (p_word_end) else $error("word program not 30 periods");
	property p_first_end;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(state_r == fpet_pkg::FPET_BFIRST && step_done) |-> run_cnt == 25;
	endproperty
	a_first_end: assert property (p_first_end) else $error("first block word not 25");
	property p_next_end;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(state_r == fpet_pkg::FPET_BNEXT && step_done) |-> run_cnt == 18;
	endproperty
	a_next_end: assert property (p_next_end) else $error("next block word not 18");
	property p_end_wait;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(state_r == fpet_pkg::FPET_BEND && step_done) |-> run_cnt == 6 ##1 DONE_OUT;
	endproperty
	a_end_wait: assert property (p_end_wait) else $error("end wait not 6 periods");
	property p_erase_end;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(state_r == fpet_pkg::FPET_ERASE && step_done) |-> (run_cnt == SEG_CYCLES ||
			run_cnt == MASS_CYCLES);
	endproperty
	a_erase_end: assert property (p_erase_end) else $error("erase length wrong");
	property p_busy_hold;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		$fell(BUSY_OUT) |-> DONE_OUT;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
	property p_busy_clear;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		DONE_OUT |-> !BUSY_OUT;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy high after done");
	property p_busy_rise;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		go_ok |=> BUSY_OUT;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy not raised on start");
	property p_done_pulse;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		DONE_OUT |=> !DONE_OUT;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_pgm_busy;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		PGM_OUT |-> BUSY_OUT;
	endproperty
	a_pgm_busy: assert property (p_pgm_busy) else $error("program step without busy");
	property p_erase_busy;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		ERASE_OUT |-> BUSY_OUT;
	endproperty
	a_erase_busy: assert property (p_erase_busy) else $error("erase step without busy");
	property p_req_excl;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		WORD_REQ_OUT |-> BUSY_OUT && !PGM_OUT && !ERASE_OUT;
	endproperty
	a_req_excl: assert property (p_req_excl) else $error("word request during a step");
	property p_pos_start;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		go_ok |=> POS_OUT == 6'h00;
	endproperty
	a_pos_start: assert property (p_pos_start) else $error("position not cleared");
	property p_pos_next;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		blk_more |=> POS_OUT == $past(POS_OUT) + 6'h01;
	endproperty
	a_pos_next: assert property (p_pos_next) else $error("position not advanced");
	property p_forced_end;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		blk_stop |=> state_r == fpet_pkg::FPET_BEND && !PGM_OUT;
	endproperty
	a_forced_end: assert property (p_forced_end) else $error("no end wait after last word");
	property p_last_pos;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		blk_stop |-> POS_OUT == LAST_POS;
	endproperty
	a_last_pos: assert property (p_last_pos) else $error("forced end before last word");
	c_word: cover property (@(posedge CLK_IN) state_r == fpet_pkg::FPET_WORD && step_done);
	c_block: cover property (@(posedge CLK_IN) state_r == fpet_pkg::FPET_BEND && step_done);
	c_erase: cover property (@(posedge CLK_IN) state_r == fpet_pkg::FPET_ERASE && step_done);
	c_forced: cover property (@(posedge CLK_IN) blk_stop);
	c_refused: cover property (@(posedge CLK_IN) START_IN && BUSY_OUT);
endmodule

// >>> verilog/fpet_timer.sv
// down counter timing one step of the sequencer
// assumes load and length come from the sequencer, same clock
`timescale 1ns/1ps
module fpet_timer #(
	parameter int CNT_W = 14
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic load_in,
	input wire logic [CNT_W-1:0] len_in,
	output logic done_out
);
	logic [CNT_W-1:0] cnt_r;
	logic run_r;
	wire last = run_r && (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
	// flags the final period, so the step spans exactly len_in periods
	assign done_out = last;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end else begin
			if (load_in) begin
				cnt_r <= len_in;
				run_r <= 1'b1;
			end else if (run_r) begin
				cnt_r <= cnt_r - 1'b1;
				if (last) run_r <= 1'b0;
			end
		end
	end
endmodule
